// file: sod_top.sv
// Safety output diagnostics: wiring checks, forced OFF, events, self-test.
// Assumes APB master on the same clock and synchronous terminal feedback.
//
// Overview of operation
// - The set of wiring faults checked follows the test-pulse enable bit.
// - Without pulses, contact is seen when OFF, ground when ON, short mixed.
// - With pulses, contact when ON and both-ON shorts are seen as well.
// - With pulses, each ON output gets a fixed-width OFF pulse in turn.
// - A detected output error is held at least the minimum hold time.
// - In dual mode an error on either terminal turns both of the pair OFF.
// - An overcurrent on a terminal turns that terminal OFF.
// - An overcurrent raises the short-circuit-at-output event.
// - An out-of-range I/O supply turns every output of the unit OFF.
// - An out-of-range I/O supply raises the supply voltage error event.
// - Supply monitoring is off while every terminal is marked unused.
// - A failed supply OFF-circuit test turns every output OFF.
// - The OFF-circuit test runs once per reset and never again.
// - Supply already on at entry to refreshing starts the test then.
// - Supply coming on after entry to refreshing starts the test then.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sod_consts.svh"

module sod_top #(
	parameter logic [31:0] PULSE_CYC = 32'(`SOD_PULSE_US * `SOD_CLK_MHZ),
	parameter logic [31:0] SLOT_CYC = 32'(`SOD_SLOT_US * `SOD_CLK_MHZ),
	parameter logic [31:0] HOLD_CYC =
		32'(`SOD_HOLD_MS * 1000 * `SOD_CLK_MHZ),
	parameter logic [31:0] OFFT_CYC = 32'(`SOD_OFFT_US * `SOD_CLK_MHZ)
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sod_pkg::sod_sense_t sense,
	input wire logic iosup_ok,
	input wire logic iosup_on,
	input wire logic refreshing,
	output logic [3:0] out_drive,
	output logic [3:0] term_fault,
	output logic iosup_cut
);

	localparam logic [15:0] SETTLE_CYC =
		16'(`SOD_SETTLE_US * `SOD_CLK_MHZ);

	sod_pkg::sod_st_t s_reg;
	sod_pkg::sod_st_t s_next;

	logic [3:0] cmd_on;
	logic [3:0] pulse;
	logic [3:0] pair_flag;
	logic [3:0] want;
	logic [3:0] det;
	logic [3:0] flag;
	logic unit_off;
	logic vmon_err;
	logic ot_start;

	// Pulling the unit off while the test cuts the supply avoids
	// reading the cut as a ground fault.
	// Start edge counts too, so no output is still on when the cut lands
	// and the supply drop cannot be mistaken for a load fault.
	assign unit_off = s_reg.volt_err || s_reg.ot_fail || ot_start ||
		(s_reg.ot == sod_pkg::SOD_OT_RUN);
	assign vmon_err = !(&s_reg.unused) && !iosup_ok;
	assign ot_start = (s_reg.ot == sod_pkg::SOD_OT_WAIT) &&
		refreshing && iosup_on;

	genvar k;
	generate
		for (k = 0; k < `SOD_NT; k++) begin : g_term
			// Dual pairs follow the even bit of the command
			assign cmd_on[k] = s_reg.dual[k / 2] ?
				s_reg.cmd[(k / 2) * 2] : s_reg.cmd[k];
			assign pulse[k] = s_reg.tp_en && (s_reg.tp_slot == 2'(k)) &&
				(s_reg.tp_cnt < PULSE_CYC);
			assign pair_flag[k] = flag[k] ||
				(s_reg.dual[k / 2] && flag[k ^ 1]);
			assign want[k] = cmd_on[k] && !s_reg.unused[k] &&
				!pair_flag[k] && !sense.ovc[k] && !unit_off &&
				!pulse[k];
			// Driven OFF and reading high: supply contact or short to the
			// partner; pulses make this reachable while ON. Driven ON and
			// reading low: ground fault. Never a ground check while OFF.
			assign det[k] = !s_reg.unused[k] &&
				(s_reg.settle[k] == 16'h0) &&
				(s_reg.drive[k] ? !sense.fb[k] : sense.fb[k]);
			sod_hold #(
				.HOLD_CYC(HOLD_CYC)
			) u_hold (
				.clock(clock),
				.rst(rst),
				.clk_en(clk_en),
				.cause(det[k] || sense.ovc[k]),
				.flag(flag[k])
			);
		end
	endgenerate

	function automatic logic [31:0] read_mux(input sod_pkg::sod_st_t s,
		input logic [3:0] f, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0;
		case (a)
			`SOD_OFS_CTRL: begin
				d[`SOD_CTRL_TP] = s.tp_en;
				d[`SOD_CTRL_DUAL +: 2] = s.dual;
				d[`SOD_CTRL_UNUSED +: 4] = s.unused;
			end
			`SOD_OFS_CMD: begin
				d[3:0] = s.cmd;
			end
			`SOD_OFS_STAT: begin
				d[`SOD_STAT_FLAG +: 4] = f;
				d[`SOD_STAT_DRIVE +: 4] = s.drive;
				d[`SOD_STAT_VERR] = s.volt_err;
				d[`SOD_STAT_OTFAIL] = s.ot_fail;
				d[`SOD_STAT_OTDONE] = (s.ot == sod_pkg::SOD_OT_DONE);
			end
			`SOD_OFS_EVT: begin
				d[`SOD_EVT_SHORT] = s.ev_short;
				d[`SOD_EVT_VOLT] = s.ev_volt;
			end
			default: begin
				d = 32'h0;
			end
		endcase
		return d;
	endfunction

	always_comb begin
		logic mapped;
		logic wr;
		logic short_set;
		logic volt_set;
		s_next = s_reg;
		short_set = 1'b0;
		volt_set = 1'b0;
		mapped = (paddr == `SOD_OFS_CTRL) || (paddr == `SOD_OFS_CMD) ||
			(paddr == `SOD_OFS_STAT) || (paddr == `SOD_OFS_EVT);
		wr = psel && penable && s_reg.pready && pwrite && mapped;

		// APB: answer is prepared in the setup cycle, so every access
		// completes on its first access edge.
		// Writes land only on that access edge, never at setup.
		if (psel && !penable && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.pslverr = !mapped;
			s_next.prdata = pwrite ? 32'h0 : read_mux(s_reg, flag, paddr);
		end else if (s_reg.pready) begin
			s_next.pready = 1'b0;
			s_next.pslverr = 1'b0;
			s_next.prdata = 32'h0;
		end
		if (wr && paddr == `SOD_OFS_CTRL) begin
			s_next.tp_en = pwdata[`SOD_CTRL_TP];
			s_next.dual = pwdata[`SOD_CTRL_DUAL +: 2];
			s_next.unused = pwdata[`SOD_CTRL_UNUSED +: 4];
		end
		if (wr && paddr == `SOD_OFS_CMD) begin
			s_next.cmd = pwdata[3:0];
		end

		// Test pulse walk: one slot per terminal, so the two halves of a
		// pair are never pulsed together and a both-ON short shows.
		if (s_reg.tp_en) begin
			if (s_reg.tp_cnt >= SLOT_CYC - 32'h1) begin
				s_next.tp_cnt = 32'h0;
				s_next.tp_slot = s_reg.tp_slot + 2'h1;
			end else begin
				s_next.tp_cnt = s_reg.tp_cnt + 32'h1;
			end
		end else begin
			s_next.tp_cnt = 32'h0;
			s_next.tp_slot = 2'h0;
		end

		// Drive and feedback settle window
		s_next.drive = want;
		for (int i = 0; i < `SOD_NT; i++) begin
			if (want[i] != s_reg.drive[i]) begin
				s_next.settle[i] = SETTLE_CYC;
			end else if (s_reg.settle[i] != 16'h0) begin
				s_next.settle[i] = s_reg.settle[i] - 16'h1;
			end
		end

		// Events: a new cause beats a same-cycle clear
		s_next.ovc_d = sense.ovc;
		s_next.volt_err = vmon_err;
		short_set = |(sense.ovc & ~s_reg.ovc_d);
		volt_set = vmon_err && !s_reg.volt_err;
		if (wr && paddr == `SOD_OFS_EVT) begin
			s_next.ev_short = s_reg.ev_short && !pwdata[`SOD_EVT_SHORT];
			s_next.ev_volt = s_reg.ev_volt && !pwdata[`SOD_EVT_VOLT];
		end
		if (short_set) begin
			s_next.ev_short = 1'b1;
		end
		if (volt_set) begin
			s_next.ev_volt = 1'b1;
		end

		// Supply OFF-circuit test: cut the supply, expect it to drop
		unique case (s_reg.ot)
			sod_pkg::SOD_OT_WAIT: begin
				if (ot_start) begin
					s_next.ot = sod_pkg::SOD_OT_RUN;
					s_next.ot_cnt = 32'h0;
					s_next.iosup_cut = 1'b1;
				end
			end
			sod_pkg::SOD_OT_RUN: begin
				if (s_reg.ot_cnt >= OFFT_CYC - 32'h1) begin
					s_next.ot = sod_pkg::SOD_OT_DONE;
					s_next.iosup_cut = 1'b0;
					s_next.ot_fail = iosup_on;
				end else begin
					s_next.ot_cnt = s_reg.ot_cnt + 32'h1;
				end
			end
			sod_pkg::SOD_OT_DONE: begin
				s_next.ot = sod_pkg::SOD_OT_DONE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.ot <= sod_pkg::SOD_OT_WAIT;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// Flag comes from the hold timer flop, the rest from s_reg
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign out_drive = s_reg.drive;
	assign term_fault = flag;
	assign iosup_cut = s_reg.iosup_cut;

	// Assertions sample only on enabled edges, as state freezes otherwise
	a_flag_forces_off: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(flag != 4'h0) |=> ((s_reg.drive & $past(flag)) == 4'h0))
		else $error("flagged terminal still driven");

	a_dual_pair_off: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(s_reg.dual[0] && (flag[0] || flag[1])) |=>
		(!s_reg.drive[0] && !s_reg.drive[1]))
		else $error("dual pair not both off after fault");

	a_ovc_off: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(sense.ovc != 4'h0) |=>
		((s_reg.drive & $past(sense.ovc)) == 4'h0))
		else $error("overcurrent terminal still driven");

	a_ovc_event: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		((sense.ovc & ~s_reg.ovc_d) != 4'h0) |=> s_reg.ev_short)
		else $error("short event not raised");

	a_short_sticky: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(s_reg.ev_short && !(psel && penable && s_reg.pready &&
		pwrite && paddr == `SOD_OFS_EVT)) |=> s_reg.ev_short)
		else $error("short event lost without a clear");

	a_volt_off: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		s_reg.volt_err |=> (s_reg.drive == 4'h0))
		else $error("outputs on during supply error");

	a_volt_event: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(!(&s_reg.unused) && !iosup_ok && !s_reg.volt_err) |=>
		(s_reg.volt_err && s_reg.ev_volt))
		else $error("supply error event not raised");

	a_vmon_unused: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		((&s_reg.unused) && !s_reg.ev_volt &&
		!(psel && pwrite && paddr == `SOD_OFS_CTRL)) |=>
		!s_reg.ev_volt)
		else $error("supply monitor active with all unused");

	a_test_start: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		ot_start |=> (s_reg.iosup_cut && s_reg.drive == 4'h0))
		else $error("off-circuit test did not start");

	a_test_once: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(s_reg.ot == sod_pkg::SOD_OT_DONE) |=>
		(s_reg.ot == sod_pkg::SOD_OT_DONE && !s_reg.iosup_cut))
		else $error("off-circuit test repeated");

	a_test_fault: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		s_reg.ot_fail |=> (s_reg.drive == 4'h0))
		else $error("outputs on after failed test");

	a_cut_off: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		s_reg.iosup_cut |=> (s_reg.drive == 4'h0))
		else $error("outputs on while supply is cut");

	a_pulse_off: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(s_reg.tp_en && s_reg.tp_cnt < PULSE_CYC) |=>
		!s_reg.drive[$past(s_reg.tp_slot)])
		else $error("output on during test pulse");

	a_tp_idle: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		!s_reg.tp_en |=> (s_reg.tp_cnt == 32'h0))
		else $error("pulse walk running while disabled");

	a_detect_gnd: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		(s_reg.drive[0] && !s_reg.unused[0] &&
		s_reg.settle[0] == 16'h0 && !sense.fb[0]) |=> flag[0])
		else $error("ground fault not flagged");

	a_ready_pulse: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		s_reg.pready |=> !s_reg.pready)
		else $error("bus ready held past one cycle");

	c_test_pass: cover property (@(posedge clock iff clk_en)
		disable iff (rst) s_reg.ot == sod_pkg::SOD_OT_DONE && !s_reg.ot_fail);
	c_short_event: cover property (@(posedge clock iff clk_en)
		disable iff (rst) $rose(s_reg.ev_short));
	c_dual_fault: cover property (@(posedge clock iff clk_en)
		disable iff (rst) s_reg.dual[0] && flag[1] && cmd_on[0]);
	c_pulse_seen: cover property (@(posedge clock iff clk_en)
		disable iff (rst) $fell(s_reg.drive[1]) && s_reg.tp_en && cmd_on[1]);
	c_volt_event: cover property (@(posedge clock iff clk_en)
		disable iff (rst) $rose(s_reg.ev_volt));

endmodule // sod_top

`default_nettype wire

// file: sod_consts.svh
// Constants of the safety output diagnostics block.
// Assumes a 50 MHz clock and four output terminals in two pairs.
`ifndef SOD_CONSTS_SVH
`define SOD_CONSTS_SVH

`define SOD_NT 4
`define SOD_CLK_MHZ 50
`define SOD_PULSE_US 640
`define SOD_SLOT_US 2500
`define SOD_HOLD_MS 1000
`define SOD_SETTLE_US 20
`define SOD_OFFT_US 100

`define SOD_OFS_CTRL 8'h00
`define SOD_OFS_CMD 8'h04
`define SOD_OFS_STAT 8'h08
`define SOD_OFS_EVT 8'h0c

`define SOD_CTRL_TP 0
`define SOD_CTRL_DUAL 1
`define SOD_CTRL_UNUSED 4
`define SOD_CTRL_RST 32'h0000_0000

`define SOD_STAT_FLAG 0
`define SOD_STAT_DRIVE 4
`define SOD_STAT_VERR 8
`define SOD_STAT_OTFAIL 9
`define SOD_STAT_OTDONE 10

`define SOD_EVT_SHORT 0
`define SOD_EVT_VOLT 1

`endif

// file: sod_pkg.sv
// Types of the safety output diagnostics block.
// Assumes four terminals, matching sod_consts.svh.
package sod_pkg;

	typedef enum logic [2:0] {
		SOD_OT_WAIT = 3'b001,
		SOD_OT_RUN = 3'b010,
		SOD_OT_DONE = 3'b100
	} sod_ot_t;

	typedef struct packed {
		logic [3:0] fb;
		logic [3:0] ovc;
	} sod_sense_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic flag;
	} sod_hold_st_t;

	typedef struct packed {
		logic tp_en;
		logic [1:0] dual;
		logic [3:0] unused;
		logic [3:0] cmd;
		logic [3:0] drive;
		logic [3:0][15:0] settle;
		logic [31:0] tp_cnt;
		logic [1:0] tp_slot;
		logic [3:0] ovc_d;
		logic volt_err;
		logic ev_short;
		logic ev_volt;
		sod_ot_t ot;
		logic [31:0] ot_cnt;
		logic ot_fail;
		logic iosup_cut;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sod_st_t;

endpackage

// file: sod_hold.sv
// Error hold timer for one output terminal.
// Assumes cause is synchronous to clock; flag stays while cause stands
// and for hold_cyc cycles after it goes away.
`timescale 1ns/1ps
`default_nettype none

module sod_hold #(
	parameter logic [31:0] HOLD_CYC = 32'h02fa_f080
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cause,
	output logic flag
);

	sod_pkg::sod_hold_st_t s_reg;
	sod_pkg::sod_hold_st_t s_next;

	always_comb begin
		s_next = s_reg;
		if (cause) begin
			s_next.cnt = HOLD_CYC;
		end else if (s_reg.cnt != 32'h0) begin
			s_next.cnt = s_reg.cnt - 32'h1;
		end
		s_next.flag = cause || (s_next.cnt != 32'h0);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign flag = s_reg.flag;

	a_hold_load: assert property (
		@(posedge clock iff clk_en) disable iff (rst)
		cause |=> (s_reg.flag && s_reg.cnt == HOLD_CYC))
		else $error("hold timer not loaded on fault");

endmodule // sod_hold

`default_nettype wire

// file: sod_act_model.sv
// Actuator and I/O supply model at the output terminals.
// Assumes drive levels from the block; wiring faults set by the bench.
`timescale 1ns/1ps
`default_nettype none

module sod_act_model (
	input wire logic [3:0] drive,
	input wire logic [3:0] stuck_hi,
	input wire logic [3:0] stuck_lo,
	input wire logic [3:0] ovc_in,
	input wire logic cut,
	input wire logic sup_on,
	input wire logic off_bad,
	output var sod_pkg::sod_sense_t sense,
	output logic iosup_on
);
	// Terminal reads back its drive unless wired to a rail
	assign sense.fb = stuck_hi | (drive & ~stuck_lo);
	assign sense.ovc = ovc_in;
	// A sound OFF circuit removes the supply while cut
	assign iosup_on = sup_on & ~(cut & ~off_bad);
endmodule // sod_act_model

`default_nettype wire

// file: safety_output_diagnostics_tb_top.sv
// Bench for the safety output diagnostics block.
// Assumes sod_top and sod_act_model; long counts shortened by parameter.
`timescale 1ns/1ps
`default_nettype none

module safety_output_diagnostics_tb_top;
	localparam logic [31:0] PUL = 32'h8;
	localparam logic [31:0] SLOT = 32'h7d0;
	localparam logic [31:0] HOLD = 32'h14;
	localparam logic [31:0] OFFT = 32'h5;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic iosup_ok = 1'b1;
	logic refreshing = 1'b0;
	logic sup_on = 1'b1;
	logic off_bad = 1'b0;
	logic [3:0] stuck_hi = 4'h0;
	logic [3:0] stuck_lo = 4'h0;
	logic [3:0] ovc_in = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic iosup_on;
	logic iosup_cut;
	logic [3:0] out_drive;
	logic [3:0] term_fault;
	sod_pkg::sod_sense_t sense;
	logic [31:0] rd;
	logic er;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int k;

	always #10 clock = ~clock;

	sod_top #(.PULSE_CYC(PUL), .SLOT_CYC(SLOT), .HOLD_CYC(HOLD),
		.OFFT_CYC(OFFT)) u_dut (
		.clock(clock), .rst(rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sense(sense), .iosup_ok(iosup_ok),
		.iosup_on(iosup_on), .refreshing(refreshing),
		.out_drive(out_drive), .term_fault(term_fault),
		.iosup_cut(iosup_cut));

	sod_act_model u_act (
		.drive(out_drive), .stuck_hi(stuck_hi), .stuck_lo(stuck_lo),
		.ovc_in(ovc_in), .cut(iosup_cut), .sup_on(sup_on),
		.off_bad(off_bad), .sense(sense), .iosup_on(iosup_on));

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; pready is seen as it stood before it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rst_dut();
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
	endtask

	// Ceiling well above the longest run, about 11000 cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		rst_dut();
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(er), 32'h1);
		repeat (10) @(posedge clock);
		chk(32'(iosup_cut), 32'h0);
		refreshing <= 1'b1;
		for (k = 0; k < 4 && iosup_cut !== 1'b1; k++) @(posedge clock);
		chk(32'(iosup_cut), 32'h1);
		repeat (20) @(posedge clock);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h400);
		refreshing <= 1'b0;
		repeat (3) @(posedge clock);
		refreshing <= 1'b1;
		for (k = 0; k < 10 && iosup_cut !== 1'b1; k++) @(posedge clock);
		chk(32'(iosup_cut), 32'h0);
		apb(1'b1, 8'h04, 32'hf);
		repeat (3) @(posedge clock);
		chk(32'(out_drive), 32'hf);
		ovc_in <= 4'h1;
		repeat (3) @(posedge clock);
		chk(32'(out_drive), 32'he);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h1);
		ovc_in <= 4'h0;
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		stuck_lo <= 4'h8;
		for (k = 0; k < 1200 && term_fault[3] !== 1'b1; k++) @(posedge clock);
		chk(32'(term_fault[3]), 32'h1);
		repeat (2) @(posedge clock);
		chk(32'(out_drive[3]), 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(rd[3]), 32'h1);
		stuck_lo <= 4'h0;
		apb(1'b1, 8'h04, 32'h3);
		stuck_hi <= 4'h4;
		for (k = 0; k < 1200 && term_fault[2] !== 1'b1; k++) @(posedge clock);
		chk(32'(term_fault[2]), 32'h1);
		stuck_hi <= 4'h0;
		for (k = 0; k < 200 && term_fault[2] === 1'b1; k++) @(posedge clock);
		chk(32'(k >= HOLD), 32'h1);
		// Second power-up: dual pair and supply range
		rst_dut();
		repeat (20) @(posedge clock);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h04, 32'h1);
		repeat (3) @(posedge clock);
		chk(32'(out_drive), 32'h3);
		stuck_lo <= 4'h2;
		for (k = 0; k < 1200 && term_fault[1] !== 1'b1; k++) @(posedge clock);
		repeat (2) @(posedge clock);
		chk(32'(out_drive), 32'h0);
		stuck_lo <= 4'h0;
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'hf);
		repeat (40) @(posedge clock);
		chk(32'(out_drive), 32'hf);
		// Enable low: the supply error must wait for the enable
		clk_en <= 1'b0;
		iosup_ok <= 1'b0;
		repeat (5) @(posedge clock);
		chk(32'(out_drive), 32'hf);
		clk_en <= 1'b1;
		repeat (3) @(posedge clock);
		chk(32'(out_drive), 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h2);
		iosup_ok <= 1'b1;
		apb(1'b1, 8'h00, 32'hf0);
		apb(1'b1, 8'h0c, 32'h3);
		iosup_ok <= 1'b0;
		repeat (5) @(posedge clock);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		iosup_ok <= 1'b1;
		// Third power-up: width of the OFF pulse
		rst_dut();
		repeat (20) @(posedge clock);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h04, 32'h1);
		for (k = 0; k < 9000 && out_drive[0] !== 1'b1; k++) @(posedge clock);
		for (k = 0; k < 9000 && out_drive[0] !== 1'b0; k++) @(posedge clock);
		for (k = 0; k < 50 && out_drive[0] === 1'b0; k++) @(posedge clock);
		chk(32'(k), PUL);
		// Fourth power-up: supply late, OFF circuit broken
		sup_on <= 1'b0;
		off_bad <= 1'b1;
		rst_dut();
		repeat (10) @(posedge clock);
		chk(32'(iosup_cut), 32'h0);
		sup_on <= 1'b1;
		for (k = 0; k < 4 && iosup_cut !== 1'b1; k++) @(posedge clock);
		chk(32'(iosup_cut), 32'h1);
		repeat (20) @(posedge clock);
		apb(1'b1, 8'h04, 32'hf);
		repeat (3) @(posedge clock);
		chk(32'(out_drive), 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h600);
		wrap_up();
	end
endmodule // safety_output_diagnostics_tb_top

`default_nettype wire
